// ### rtl/sps_pkg.sv
// Constants, types and the protection decode for the status/protect block.
// Assumes one 100 MHz system clock; all pins arrive asynchronously.
package sps_pkg;

  // ******************************************************
  // Command codes
  // ******************************************************
  localparam logic [7:0] CMD_SET_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
  localparam logic [7:0] CMD_STAT_RD   = 8'h05;
  localparam logic [7:0] CMD_STAT_WR   = 8'h01;
  localparam logic [7:0] CMD_MEM_WR    = 8'h02;

  // ******************************************************
  // Status layout and memory geometry
  // ******************************************************
  localparam int         SR_LOCK   = 7;
  localparam int         SR_SIZE_H = 3;
  localparam int         SR_SIZE_L = 2;
  localparam int         SR_LATCH  = 1;
  localparam int         SR_BUSY   = 0;
  localparam int         ADDR_W    = 13;
  localparam int         ADDR_HI_W = 5;
  localparam logic [12:0] PROT_QTR  = 13'h1800;
  localparam logic [12:0] PROT_HALF = 13'h1000;
  localparam logic [12:0] PROT_ALL  = 13'h0000;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_MHZ       = 100;
  localparam int WRITE_TIME_US = 5000;
  localparam int WR_CYCLES_DFLT = WRITE_TIME_US * CLK_MHZ;
  localparam int TMR_W          = 20;

  // ******************************************************
  // Types
  // ******************************************************
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
  } sps_pins_t;

  localparam sps_pins_t PINS_RST = '{sclk: 1'b0, cs_n: 1'b1,
                                     mosi: 1'b0, wp_n: 1'b1};

  typedef struct packed {
    sps_pins_t s1;
    sps_pins_t s2;
  } sps_sync_t;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [TMR_W-1:0] cnt;
  } sps_tmr_t;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_CMD   = 9'h002,
    S_HOLD  = 9'h004,
    S_RDST  = 9'h008,
    S_WSDAT = 9'h010,
    S_WSEND = 9'h020,
    S_WMADR = 9'h040,
    S_WMDAT = 9'h080,
    S_SKIP  = 9'h100
  } sps_state_t;

  typedef struct packed {
    sps_state_t  state;
    logic        sclk_d;
    logic        cs_d;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  cmd;
    logic        adr_lo;
    logic        have_data;
    logic [12:0] mem_addr;
    logic [7:0]  mem_data;
    logic [2:0]  tx_cnt;
    logic [6:0]  tx_sh;
    logic        miso;
    logic        miso_oe;
    logic        latch;
    logic        lock;
    logic [1:0]  size;
    logic        pend_lock;
    logic [1:0]  pend_size;
    logic        stat_cyc;
    logic        wr_go;
    logic        mem_start;
  } sps_core_t;

  // Protected-area hit for a memory write start address
  function automatic logic prot_hit(input logic [12:0] addr,
                                    input logic [1:0]  size);
    logic hit;
    hit = 1'b0;
    case (size)
      2'h1:    hit = (addr >= PROT_QTR);
      2'h2:    hit = (addr >= PROT_HALF);
      2'h3:    hit = (addr >= PROT_ALL);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// ### rtl/sps_sync.sv
// Two-stage synchronisers for the serial and protect pins.
// Assumes pins are asynchronous to ref_clk.
`timescale 1ns/1ns
module sps_sync (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  wire sps_pkg::sps_pins_t pin_in,
  output sps_pkg::sps_pins_t     pin_out
);

  sps_pkg::sps_sync_t st_r;
  sps_pkg::sps_sync_t st_nxt;

  // First stage feeds only the second
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '{s1: sps_pkg::PINS_RST, s2: sps_pkg::PINS_RST};
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign pin_out = st_r.s2;

endmodule

// ### rtl/sps_wr_timer.sv
// Self-timed nonvolatile write cycle timer.
// Assumes start is a one-cycle pulse on ref_clk, ignored while busy.
`timescale 1ns/1ns
module sps_wr_timer #(
  parameter logic [19:0] WR_CYCLES = 20'(sps_pkg::WR_CYCLES_DFLT)
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  sps_pkg::sps_tmr_t st_r;
  sps_pkg::sps_tmr_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && start)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = WR_CYCLES - 20'h00001;
    end
    else if (st_r.busy && st_r.cnt == '0)
    begin
      st_nxt.busy = 1'b0;
      st_nxt.done = 1'b1;
    end
    else if (st_r.busy)
      st_nxt.cnt = st_r.cnt - 20'h00001;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule

// ### rtl/sps_core.sv
// Serial status register, write latch and protection logic.
// Assumes an SPI master in mode 0 or 3 with a serial clock well below
// a quarter of ref_clk; all pins are resynchronised here.
`timescale 1ns/1ns
module sps_core #(
  parameter logic [19:0] WR_CYCLES = 20'(sps_pkg::WR_CYCLES_DFLT)
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic        wp_n,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic             mem_wr_start,
  output logic [12:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  output logic             hw_lock_mode
);

  // ******************************************************
  // Pin synchronisers and write timer
  // ******************************************************
  sps_pkg::sps_pins_t pin_raw;
  sps_pkg::sps_pins_t pin_s;
  logic               tmr_busy;
  logic               tmr_done;
  sps_pkg::sps_core_t st_r;
  sps_pkg::sps_core_t st_nxt;

  assign pin_raw = '{sclk: spi_sclk, cs_n: spi_cs_n,
                     mosi: spi_mosi, wp_n: wp_n};

  sps_sync u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .pin_in  (pin_raw),
    .pin_out (pin_s)
  );

  sps_wr_timer #(
    .WR_CYCLES (WR_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .start   (st_r.wr_go),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // ******************************************************
  // Edges, protection and status image
  // ******************************************************
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic       byte_end;
  logic [7:0] rx_byte;
  logic       hw_lock;
  logic [7:0] stat_now;

  assign sclk_rise = pin_s.sclk & ~st_r.sclk_d;
  assign sclk_fall = ~pin_s.sclk & st_r.sclk_d;
  assign cs_rise   = pin_s.cs_n & ~st_r.cs_d;
  assign cs_fall   = ~pin_s.cs_n & st_r.cs_d;
  assign rx_byte   = {st_r.rx_sh[6:0], pin_s.mosi};
  assign byte_end  = sclk_rise && (st_r.bit_cnt == sps_pkg::BIT_LAST);
  // Level only: entered in either order, left when the pin rises
  assign hw_lock   = st_r.lock & ~pin_s.wp_n;

  always_comb
  begin
    stat_now                     = 8'h00;
    stat_now[sps_pkg::SR_LOCK]   = st_r.lock;
    stat_now[sps_pkg::SR_SIZE_H] = st_r.size[1];
    stat_now[sps_pkg::SR_SIZE_L] = st_r.size[0];
    stat_now[sps_pkg::SR_LATCH]  = st_r.latch;
    stat_now[sps_pkg::SR_BUSY]   = tmr_busy;
  end

  // ******************************************************
  // Command sequencer
  // ******************************************************
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.wr_go     = 1'b0;
    st_nxt.mem_start = 1'b0;
    st_nxt.sclk_d    = pin_s.sclk;
    st_nxt.cs_d      = pin_s.cs_n;
    // Cycle end first, so a set in the same cycle wins
    if (tmr_done)
    begin
      st_nxt.latch = 1'b0;
      if (st_r.stat_cyc)
      begin
        st_nxt.lock = st_r.pend_lock;
        st_nxt.size = st_r.pend_size;
      end
    end
    if (cs_fall)
    begin
      st_nxt.state   = sps_pkg::S_CMD;
      st_nxt.bit_cnt = 3'h0;
    end
    else if (cs_rise)
    begin
      st_nxt.state   = sps_pkg::S_IDLE;
      st_nxt.miso    = 1'b0;
      st_nxt.miso_oe = 1'b0;
      case (st_r.state)
        sps_pkg::S_HOLD:
        begin
          if (!tmr_busy && st_r.cmd == sps_pkg::CMD_SET_LATCH)
            st_nxt.latch = 1'b1;
          else if (!tmr_busy)
            st_nxt.latch = 1'b0;
        end
        sps_pkg::S_WSEND:
        begin
          // Lock bit 0 or pin high: latch and busy flag alone decide
          if (st_r.latch && !tmr_busy && !hw_lock)
          begin
            st_nxt.pend_lock = st_r.rx_sh[sps_pkg::SR_LOCK];
            st_nxt.pend_size = st_r.rx_sh[sps_pkg::SR_SIZE_H:
                                          sps_pkg::SR_SIZE_L];
            st_nxt.stat_cyc  = 1'b1;
            st_nxt.wr_go     = 1'b1;
          end
        end
        sps_pkg::S_WMDAT:
        begin
          if (st_r.bit_cnt == 3'h0 && st_r.have_data && st_r.latch &&
              !tmr_busy &&
              !sps_pkg::prot_hit(st_r.mem_addr, st_r.size))
          begin
            st_nxt.stat_cyc  = 1'b0;
            st_nxt.wr_go     = 1'b1;
            st_nxt.mem_start = 1'b1;
          end
        end
        default:
        begin
          st_nxt.state = sps_pkg::S_IDLE;
        end
      endcase
    end
    else if (!pin_s.cs_n)
    begin
      if (sclk_rise)
      begin
        st_nxt.rx_sh   = rx_byte;
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        case (st_r.state)
          sps_pkg::S_CMD:
          begin
            if (byte_end)
            begin
              st_nxt.cmd = rx_byte;
              case (rx_byte)
                sps_pkg::CMD_SET_LATCH,
                sps_pkg::CMD_CLR_LATCH:
                  st_nxt.state = sps_pkg::S_HOLD;
                sps_pkg::CMD_STAT_RD:
                begin
                  st_nxt.state   = sps_pkg::S_RDST;
                  st_nxt.tx_cnt  = 3'h0;
                  st_nxt.miso_oe = 1'b1;
                end
                sps_pkg::CMD_STAT_WR:
                  st_nxt.state = sps_pkg::S_WSDAT;
                sps_pkg::CMD_MEM_WR:
                begin
                  st_nxt.state     = sps_pkg::S_WMADR;
                  st_nxt.adr_lo    = 1'b0;
                  st_nxt.have_data = 1'b0;
                end
                default:
                  st_nxt.state = sps_pkg::S_SKIP;
              endcase
            end
          end
          sps_pkg::S_WSDAT:
          begin
            if (byte_end)
              st_nxt.state = sps_pkg::S_WSEND;
          end
          sps_pkg::S_HOLD,
          sps_pkg::S_WSEND:
            st_nxt.state = sps_pkg::S_SKIP;
          sps_pkg::S_WMADR:
          begin
            if (byte_end && !st_r.adr_lo)
            begin
              st_nxt.mem_addr[12:8] = rx_byte[sps_pkg::ADDR_HI_W-1:0];
              st_nxt.adr_lo         = 1'b1;
            end
            else if (byte_end)
            begin
              st_nxt.mem_addr[7:0] = rx_byte;
              st_nxt.state         = sps_pkg::S_WMDAT;
            end
          end
          sps_pkg::S_WMDAT:
          begin
            if (byte_end)
            begin
              st_nxt.mem_data  = rx_byte;
              st_nxt.have_data = 1'b1;
            end
          end
          default:
          begin
            st_nxt.state = st_r.state;
          end
        endcase
      end
      // Data goes out after the falling edge; reload gives live polling
      if (sclk_fall && st_r.state == sps_pkg::S_RDST)
      begin
        st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
        if (st_r.tx_cnt == 3'h0)
        begin
          st_nxt.miso  = stat_now[7];
          st_nxt.tx_sh = stat_now[6:0];
        end
        else
        begin
          st_nxt.miso  = st_r.tx_sh[6];
          st_nxt.tx_sh = {st_r.tx_sh[5:0], 1'b0};
        end
      end
    end
  end

  // Nonvolatile bits take their blank state at reset; no array behind
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r       <= '0;
      st_r.state <= sps_pkg::S_IDLE;
      st_r.cs_d  <= 1'b1;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign spi_miso     = st_r.miso;
  assign spi_miso_oe  = st_r.miso_oe;
  assign mem_wr_start = st_r.mem_start;
  assign mem_wr_addr  = st_r.mem_addr;
  assign mem_wr_data  = st_r.mem_data;
  assign hw_lock_mode = hw_lock;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clk_en);

  chk_set_latch: assert property (
    cs_rise && st_r.state == sps_pkg::S_HOLD && !tmr_busy &&
    st_r.cmd == sps_pkg::CMD_SET_LATCH |=> st_r.latch)
    else $error("set-latch command did not set latch");

  chk_clr_latch: assert property (
    cs_rise && st_r.state == sps_pkg::S_HOLD && !tmr_busy &&
    st_r.cmd == sps_pkg::CMD_CLR_LATCH |=> !st_r.latch)
    else $error("clear-latch command did not clear latch");

  chk_done_clears: assert property (
    tmr_done && !(cs_rise && st_r.state == sps_pkg::S_HOLD &&
    st_r.cmd == sps_pkg::CMD_SET_LATCH) |=> !st_r.latch)
    else $error("latch survived end of write cycle");

  chk_go_latched: assert property (
    st_r.wr_go |-> $past(st_r.latch) && !$past(tmr_busy))
    else $error("write cycle started without latch");

  chk_hwlock_rej: assert property (
    st_r.wr_go && st_r.stat_cyc |-> !$past(hw_lock))
    else $error("status write accepted in hardware lock");

  chk_nv_stable: assert property (
    tmr_busy |=> $stable(st_r.lock) && $stable(st_r.size))
    else $error("lock or size changed during write cycle");

  chk_busy_start: assert property (
    st_r.wr_go |=> tmr_busy ##1 (tmr_busy || tmr_done))
    else $error("busy not raised by write start");

  chk_rsvd_zero: assert property (
    sclk_fall && !pin_s.cs_n && st_r.state == sps_pkg::S_RDST &&
    st_r.tx_cnt inside {3'h1, 3'h2, 3'h3} |=> !st_r.miso)
    else $error("reserved status bit read as one");

  chk_poll_reload: assert property (
    sclk_fall && !pin_s.cs_n && st_r.state == sps_pkg::S_RDST &&
    st_r.tx_cnt == 3'h0 |=> st_r.miso == $past(st_r.lock))
    else $error("status byte not reloaded on repeat");

  chk_prot_block: assert property (
    st_r.mem_start |-> !sps_pkg::prot_hit(st_r.mem_addr, st_r.size))
    else $error("write started in protected area");

  chk_skip_nogo: assert property (
    cs_rise && st_r.state == sps_pkg::S_SKIP && !tmr_done |=>
    !st_r.wr_go && $stable(st_r.latch))
    else $error("extra clock did not abort command");

endmodule

// ### test/sps_spi_master.sv
// Serial bus master model that stands on the far side of sps_core.
// Assumes ref_clk at 100 MHz; serial clock of 80 ns, mode 0, MSB first.
`timescale 1ns/1ns
module sps_spi_master (
  input  wire logic ref_clk,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi
);
  // ****************************************
  // Link idle state
  // ****************************************
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Falling edge of select opens every frame
  task automatic sel();
    spi_cs_n <= 1'b0;
    tick(4);
  endtask

  // Select rises while the clock is still high after the last rise
  task automatic desel();
    spi_cs_n <= 1'b1;
    tick(4);
    spi_sclk <= 1'b0;
    spi_mosi <= ~spi_mosi;
    tick(8);
  endtask

  // Sampled mid high phase, well after the output settles
  task automatic xbit(input logic b, output logic r);
    spi_sclk <= 1'b0;
    spi_mosi <= b;
    tick(4);
    spi_sclk <= 1'b1;
    tick(2);
    #1 r = spi_miso_oe ? spi_miso : 1'bx;
    tick(2);
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      xbit(tx[i], rx[i]);
  endtask
endmodule

// ### test/spi_eeprom_status_protection_tb.sv
// Self-checking bench for the status and protection logic.
// Assumes sps_core and the sps_spi_master model; write cycle shortened.
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); \
    end \
  end
module spi_eeprom_status_protection_tb;
  logic        ref_clk;
  logic        rstn;
  logic        clk_en;
  logic        wp_n;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        mw_go;
  logic [12:0] mw_addr;
  logic [7:0]  mw_data;
  logic        hw_lock;
  logic [12:0] got_addr;
  logic [7:0]  got_data;
  int          n_mw;
  int          bad_count;
  int          n_checks;
  logic [7:0]  s;

  sps_core #(.WR_CYCLES(20'h000C8)) u_dut (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .clk_en       (clk_en),
    .spi_sclk     (sclk),
    .spi_cs_n     (cs_n),
    .spi_mosi     (mosi),
    .wp_n         (wp_n),
    .spi_miso     (miso),
    .spi_miso_oe  (miso_oe),
    .mem_wr_start (mw_go),
    .mem_wr_addr  (mw_addr),
    .mem_wr_data  (mw_data),
    .hw_lock_mode (hw_lock)
  );

  sps_spi_master m (
    .ref_clk     (ref_clk),
    .spi_miso    (miso),
    .spi_miso_oe (miso_oe),
    .spi_sclk    (sclk),
    .spi_cs_n    (cs_n),
    .spi_mosi    (mosi)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (mw_go === 1'b1)
    begin
      n_mw++;
      got_addr = mw_addr;
      got_data = mw_data;
    end

  // ****************************************
  // Frame helpers
  // ****************************************
  task automatic cmd(input logic [7:0] c, input logic extra);
    logic [7:0] r;
    logic       r1;
    m.sel();
    m.xbyte(c, r);
    if (extra)
      m.xbit(1'b0, r1);
    m.desel();
  endtask

  task automatic wrs(input logic [7:0] d, input logic extra);
    logic [7:0] r;
    logic       r1;
    m.sel();
    m.xbyte(8'h01, r);
    m.xbyte(d, r);
    if (extra)
      m.xbit(1'b0, r1);
    m.desel();
  endtask

  task automatic mwr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    m.sel();
    m.xbyte(8'h02, r);
    m.xbyte(a[15:8], r);
    m.xbyte(a[7:0], r);
    m.xbyte(d, r);
    m.desel();
  endtask

  task automatic rd(output logic [7:0] st, input logic twice);
    logic [7:0] r;
    m.sel();
    m.xbyte(8'h05, r);
    `CHK(miso_oe, 1'b1);
    m.xbyte(8'h00, st);
    if (twice)
    begin
      m.xbyte(8'h00, r);
      `CHK(r, st);
    end
    m.desel();
  endtask

  // Bounded poll of the busy flag
  task automatic wait_idle(output logic [7:0] st);
    for (int i = 0; i < 12; i++)
    begin
      rd(st, 1'b0);
      if (st[0] === 1'b0)
        break;
    end
    `CHK(st[0], 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(s, 1'b0);
    `CHK(s, 8'h00);
    `CHK(hw_lock, 1'b0);
    `CHK(miso_oe, 1'b0);
  endtask

  task automatic t_latch();
    cmd(8'h06, 1'b1);
    rd(s, 1'b0);
    `CHK(s, 8'h00);
    cmd(8'h06, 1'b0);
    rd(s, 1'b1);
    `CHK(s, 8'h02);
    cmd(8'h03, 1'b0);
    cmd(8'h04, 1'b1);
    rd(s, 1'b0);
    `CHK(s, 8'h02);
    cmd(8'h04, 1'b0);
    rd(s, 1'b0);
    `CHK(s, 8'h00);
  endtask

  task automatic t_stwr();
    wrs(8'h8C, 1'b0);
    rd(s, 1'b0);
    `CHK(s, 8'h00);
    cmd(8'h06, 1'b0);
    wrs(8'hFF, 1'b1);
    rd(s, 1'b0);
    `CHK(s, 8'h02);
    wrs(8'hFF, 1'b0);
    rd(s, 1'b0);
    `CHK(s, 8'h03);
    wait_idle(s);
    `CHK(s, 8'h8C);
  endtask

  task automatic t_lock();
    wp_n <= 1'b0;
    m.tick(6);
    `CHK(hw_lock, 1'b1);
    cmd(8'h06, 1'b0);
    wrs(8'h00, 1'b0);
    m.tick(250);
    rd(s, 1'b0);
    `CHK(s, 8'h8E);
    wp_n <= 1'b1;
    m.tick(6);
    `CHK(hw_lock, 1'b0);
    wrs(8'h00, 1'b0);
    wait_idle(s);
    `CHK(s, 8'h00);
    wp_n <= 1'b0;
    cmd(8'h06, 1'b0);
    wrs(8'h84, 1'b0);
    wait_idle(s);
    `CHK(s, 8'h84);
    `CHK(hw_lock, 1'b1);
    wp_n <= 1'b1;
    m.tick(6);
  endtask

  // Upper quarter protected; top address bits ignored
  task automatic t_mem();
    cmd(8'h06, 1'b0);
    mwr(16'hF7FF, 8'hA5);
    `CHK(n_mw, 1);
    `CHK(got_addr, 13'h17FF);
    `CHK(got_data, 8'hA5);
    wait_idle(s);
    `CHK(s, 8'h84);
    cmd(8'h06, 1'b0);
    mwr(16'h1800, 8'h5A);
    m.tick(20);
    `CHK(n_mw, 1);
  endtask

  // Reset in mid-cycle, then a frozen clock hides a whole command
  task automatic t_restart();
    cmd(8'h06, 1'b0);
    wrs(8'h80, 1'b0);
    rd(s, 1'b0);
    `CHK(s, 8'h87);
    rstn <= 1'b0;
    m.tick(2);
    rstn <= 1'b1;
    m.tick(4);
    rd(s, 1'b0);
    `CHK(s, 8'h00);
    clk_en <= 1'b0;
    cmd(8'h06, 1'b0);
    clk_en <= 1'b1;
    rd(s, 1'b0);
    `CHK(s, 8'h00);
    cmd(8'h06, 1'b0);
    rd(s, 1'b0);
    `CHK(s, 8'h02);
  endtask

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    clk_en = 1'b1;
    wp_n = 1'b1;
    m.tick(6);
    rstn <= 1'b1;
    m.tick(6);
    t_reset();
    t_latch();
    t_stwr();
    t_lock();
    t_mem();
    t_restart();
    summarize();
  end

  // Roughly ten times the expected run length
  initial
  begin
    #600000;
    bad_count++;
    summarize();
  end
endmodule
